// [include/tmw_pkg.sv]
// shared constants for the 8-bit timer waveform block
package tmw_pkg;

   // register byte offsets on the avalon slave
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_COUNT = 4'h4;
   localparam logic [3:0] OFS_COMPARE = 4'h8;
   localparam logic [3:0] OFS_STATUS = 4'hC;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;

   // ctrl field positions, all inside byte lane 0 except the port level bit in lane 1
   localparam int CTRL_MODE_LO = 0;
   localparam int CTRL_COM_LO = 2;
   localparam int CTRL_CSEL_LO = 4;
   localparam int CTRL_DIR_BIT = 7;
   localparam int CTRL_PORT_BIT = 8;

   // status field positions
   localparam int STAT_OVF_BIT = 0;
   localparam int STAT_CMP_BIT = 1;
   localparam int STAT_OC_BIT = 2;

   // waveform modes, coded as the mode select field
   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_PHASE,
      MODE_CLEAR_ON_MATCH,
      MODE_FAST
   } tmw_mode_type;

   // compare output mode values
   localparam logic [1:0] COM_OFF = 2'h0;
   localparam logic [1:0] COM_TOGGLE = 2'h1;
   localparam logic [1:0] COM_NONINV = 2'h2;
   localparam logic [1:0] COM_INV = 2'h3;

   // prescale divisors as terminal masks (divisor minus one)
   localparam logic [9:0] DIV8_MASK = 10'h007;
   localparam logic [9:0] DIV32_MASK = 10'h01F;
   localparam logic [9:0] DIV64_MASK = 10'h03F;
   localparam logic [9:0] DIV128_MASK = 10'h07F;
   localparam logic [9:0] DIV256_MASK = 10'h0FF;
   localparam logic [9:0] DIV1024_MASK = 10'h3FF;
   localparam int PRE_W = 10;

   // clock select codes
   localparam logic [2:0] CSEL_STOP = 3'h0;
   localparam logic [2:0] CSEL_DIV1 = 3'h1;
   localparam logic [2:0] CSEL_DIV8 = 3'h2;
   localparam logic [2:0] CSEL_DIV32 = 3'h3;
   localparam logic [2:0] CSEL_DIV64 = 3'h4;
   localparam logic [2:0] CSEL_DIV128 = 3'h5;
   localparam logic [2:0] CSEL_DIV256 = 3'h6;

endpackage

// [src/tmw_prescaler.sv]
`timescale 1ns/1ps
`default_nettype none
// timer clock enable: one pulse every n core clocks
module tmw_prescaler
(
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [2:0] csel_i,
   output logic tick_o
);

   // free-running divider count
   logic [tmw_pkg::PRE_W-1:0] pre_cnt;
   // terminal mask for the selected divisor
   logic [tmw_pkg::PRE_W-1:0] mask;
   // divider reached its terminal value
   wire at_term;
   wire next_tick;

   // divisor decode, stop gives no tick at all
   always_comb
   begin
      case (csel_i)
         tmw_pkg::CSEL_DIV8: mask = tmw_pkg::DIV8_MASK;
         tmw_pkg::CSEL_DIV32: mask = tmw_pkg::DIV32_MASK;
         tmw_pkg::CSEL_DIV64: mask = tmw_pkg::DIV64_MASK;
         tmw_pkg::CSEL_DIV128: mask = tmw_pkg::DIV128_MASK;
         tmw_pkg::CSEL_DIV256: mask = tmw_pkg::DIV256_MASK;
         default: mask = tmw_pkg::DIV1024_MASK;
      endcase
   end

   assign at_term = (pre_cnt & mask) == mask;
   assign next_tick = (csel_i == tmw_pkg::CSEL_DIV1) ||
                      ((csel_i != tmw_pkg::CSEL_STOP) && at_term);

   // divider and registered tick; shared counter keeps all taps in phase
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pre_cnt <= '0;
         tick_o <= 1'b0;
      end
      else if (ce_i)
      begin
         pre_cnt <= pre_cnt + 1'b1;
         tick_o <= next_tick;
      end
   end

endmodule
`default_nettype wire

// [src/tmw_timer.sv]
// What this block does
// - mode 2 clears counter after compare match
// - mode 2 compare unbuffered; missed match wraps
// - mode 2 toggle setting inverts output on match
// - mode 2 sets compare flag at top
// - mode 2 overflow flag on max-to-zero
// - mode 3 counts to max, then clears
// - fast pwm: clear/set on match, opposite at bottom
// - fast pwm overflow flag at maximum
// - prescaler divides by 1..1024, selectable
// - fast pwm extremes: spike or constant level
// - fast pwm toggle setting, compare still buffered
// - mode 1 counts up, holds max, down
// - phase pwm: clear up-match, set down-match
// - phase pwm overflow flag at bottom
// - phase pwm extremes give constant levels
// - phase pwm symmetry transitions without match
// - pin driven only when direction is output
// - phase pwm always uses full range
// - mode 0 counts up and wraps
// - pwm compare buffered, others written directly
// - output mode 0 never touches output
//
// Implementation choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module tmw_timer
#(
   parameter int CNT_W = 8
)
(
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   // avalon-mm slave
   input wire logic [tmw_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [tmw_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   output logic [tmw_pkg::DATA_W-1:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // waveform pin as two signals
   output logic WAVE_PIN_O,
   output logic WAVE_PIN_OE_O
);

   // widths the counter and bus cannot carry, refused at elaboration
   if (CNT_W < 2 || CNT_W > tmw_pkg::CTRL_PORT_BIT)
   begin : g_bad_width
      $error("tmw_timer: CNT_W out of range");
   end

   localparam logic [CNT_W-1:0] CNT_MAX = '1;
   localparam logic [CNT_W-1:0] CNT_BOTTOM = '0;
   localparam int PAD_W = tmw_pkg::DATA_W - CNT_W;

   // software-visible control state
   tmw_pkg::tmw_mode_type mode; // waveform mode select
   logic [1:0] com; // compare output mode
   logic [2:0] csel; // clock select
   logic pin_dir; // pin direction, 1 = output
   logic port_level; // plain port level when com is off

   // counting state
   logic [CNT_W-1:0] counter_value;
   logic count_down; // phase pwm direction
   logic [CNT_W-1:0] compare_value; // active compare
   logic [CNT_W-1:0] compare_buf; // pwm double buffer
   logic match_block; // one timer cycle after a count write
   logic overflow_flag;
   logic compare_match_flag;
   logic waveform_output; // internal output compare level

   // bus handshake
   wire req = AVS_READ_I || AVS_WRITE_I;
   wire accept = req && !AVS_WAITREQUEST_O;
   wire wr_lane0 = AVS_WRITE_I && accept && AVS_BYTEENABLE_I[0];
   wire wr_lane1 = AVS_WRITE_I && accept && AVS_BYTEENABLE_I[1];

   // address decode
   wire sel_ctrl = AVS_ADDRESS_I == tmw_pkg::OFS_CTRL;
   wire sel_count = AVS_ADDRESS_I == tmw_pkg::OFS_COUNT;
   wire sel_compare = AVS_ADDRESS_I == tmw_pkg::OFS_COMPARE;
   wire sel_status = AVS_ADDRESS_I == tmw_pkg::OFS_STATUS;
   wire wr_ctrl = wr_lane0 && sel_ctrl;
   wire wr_count = wr_lane0 && sel_count;
   wire wr_compare = wr_lane0 && sel_compare;
   wire wr_status = wr_lane0 && sel_status;
   wire [CNT_W-1:0] wdata = AVS_WRITEDATA_I[CNT_W-1:0];

   // timer clock enable from the prescaler
   logic tick;

   tmw_prescaler u_pre
   (
      .clk_i(CORE_CLK_I),
      .nrst_i(NRST_I),
      .ce_i(CE_I),
      .csel_i(csel),
      .tick_o(tick)
   );

   // mode classification
   wire is_pwm = (mode == tmw_pkg::MODE_FAST) || (mode == tmw_pkg::MODE_PHASE);
   wire is_fast = mode == tmw_pkg::MODE_FAST;
   wire is_phase = mode == tmw_pkg::MODE_PHASE;
   wire is_ctc = mode == tmw_pkg::MODE_CLEAR_ON_MATCH;

   // counter position decode
   wire at_max = counter_value == CNT_MAX;
   wire at_bottom = counter_value == CNT_BOTTOM;
   // a count write suppresses a match at the written value until the next tick
   wire match = (counter_value == compare_value) && !match_block;
   wire step = tick && !wr_count;

   // phase pwm turning points; the full range is always used
   wire phase_top = is_phase && at_max && !count_down;
   wire phase_bot = is_phase && at_bottom && count_down;
   // fast pwm wrap from max back to bottom
   wire fast_wrap = is_fast && at_max;

   // next counter value per mode
   logic [CNT_W-1:0] next_count;
   logic next_down;

   always_comb
   begin
      next_count = counter_value + 1'b1;
      next_down = count_down;
      case (mode)
         tmw_pkg::MODE_CLEAR_ON_MATCH:
         begin
            // match clears; a lower compare write wraps via max
            if (match)
               next_count = CNT_BOTTOM;
         end
         tmw_pkg::MODE_FAST:
         begin
            if (at_max)
               next_count = CNT_BOTTOM;
         end
         tmw_pkg::MODE_PHASE:
         begin
            // max is held one timer cycle by turning on it
            if (phase_top)
            begin
               next_down = 1'b1;
               next_count = counter_value - 1'b1;
            end
            else if (phase_bot)
            begin
               next_down = 1'b0;
               next_count = counter_value + 1'b1;
            end
            else if (count_down)
               next_count = counter_value - 1'b1;
         end
         default:
         begin
            next_down = 1'b0;
         end
      endcase
      if (!is_phase)
         next_down = 1'b0;
   end

   // overflow event per mode
   wire ovf_evt = step && (is_phase ? phase_bot : at_max);
   // compare flag event; in ctc this is reaching top
   wire cmp_evt = step && match;

   // compare value the buffer will hand over this step
   wire load_buf = step && (fast_wrap || phase_top);
   wire [CNT_W-1:0] cmp_eff = load_buf ? compare_buf : compare_value;

   // level the pwm output takes on a clear or set action
   wire inv = com == tmw_pkg::COM_INV;
   wire lvl_clr = inv;
   wire lvl_set = !inv;
   wire pwm_com = (com == tmw_pkg::COM_NONINV) || inv;

   // next waveform level
   logic next_wave;

   always_comb
   begin
      next_wave = waveform_output;
      if (com == tmw_pkg::COM_OFF)
         next_wave = waveform_output;
      else if (is_fast)
      begin
         if (com == tmw_pkg::COM_TOGGLE)
         begin
            if (match)
               next_wave = !waveform_output;
         end
         else if (at_max)
            next_wave = lvl_set;
         else if (match)
            next_wave = lvl_clr;
      end
      else if (is_phase)
      begin
         if (pwm_com)
         begin
            // turning points force the symmetric level
            if (phase_top)
               next_wave = (cmp_eff == CNT_MAX) ? lvl_set : lvl_clr;
            else if (phase_bot)
               next_wave = (compare_value == CNT_BOTTOM) ? lvl_clr : lvl_set;
            else if (match && !count_down)
               next_wave = lvl_clr;
            else if (match)
               next_wave = lvl_set;
         end
      end
      else if (match)
      begin
         // normal and ctc: toggle, clear or set
         case (com)
            tmw_pkg::COM_TOGGLE: next_wave = !waveform_output;
            tmw_pkg::COM_NONINV: next_wave = 1'b0;
            default: next_wave = 1'b1;
         endcase
      end
   end

   // control register writes
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         mode <= tmw_pkg::MODE_NORMAL;
         com <= tmw_pkg::COM_OFF;
         csel <= tmw_pkg::CSEL_STOP;
         pin_dir <= 1'b0;
         port_level <= 1'b0;
      end
      else if (CE_I)
      begin
         if (wr_ctrl)
         begin
            mode <= tmw_pkg::tmw_mode_type'(AVS_WRITEDATA_I[tmw_pkg::CTRL_MODE_LO +: 2]);
            com <= AVS_WRITEDATA_I[tmw_pkg::CTRL_COM_LO +: 2];
            csel <= AVS_WRITEDATA_I[tmw_pkg::CTRL_CSEL_LO +: 3];
            pin_dir <= AVS_WRITEDATA_I[tmw_pkg::CTRL_DIR_BIT];
         end
         if (wr_lane1 && sel_ctrl)
            port_level <= AVS_WRITEDATA_I[tmw_pkg::CTRL_PORT_BIT];
      end
   end

   // counter, direction and match blocking
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         counter_value <= '0;
         count_down <= 1'b0;
         match_block <= 1'b0;
      end
      else if (CE_I)
      begin
         if (wr_count)
         begin
            // software write wins over a tick in the same cycle
            counter_value <= wdata;
            match_block <= 1'b1;
         end
         else if (tick)
         begin
            counter_value <= next_count;
            count_down <= next_down;
            match_block <= 1'b0;
         end
      end
   end

   // compare value: buffered in pwm modes, direct otherwise
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         compare_value <= '0;
         compare_buf <= '0;
      end
      else if (CE_I)
      begin
         if (wr_compare)
            compare_buf <= wdata;
         if (wr_compare && !is_pwm)
            compare_value <= wdata;
         else if (load_buf)
            compare_value <= compare_buf;
      end
   end

   // sticky flags, write one to clear; a same-cycle event wins
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         overflow_flag <= 1'b0;
         compare_match_flag <= 1'b0;
      end
      else if (CE_I)
      begin
         if (ovf_evt)
            overflow_flag <= 1'b1;
         else if (wr_status && AVS_WRITEDATA_I[tmw_pkg::STAT_OVF_BIT])
            overflow_flag <= 1'b0;
         if (cmp_evt)
            compare_match_flag <= 1'b1;
         else if (wr_status && AVS_WRITEDATA_I[tmw_pkg::STAT_CMP_BIT])
            compare_match_flag <= 1'b0;
      end
   end

   // internal waveform level keeps its value across mode changes
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
         waveform_output <= 1'b0;
      else if (CE_I && step)
         waveform_output <= next_wave;
   end

   // pin drive: waveform overrides port level when com is not off
   wire next_wave_pin = waveform_output;
   wire next_pin = (com != tmw_pkg::COM_OFF) ? next_wave_pin : port_level;

   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         WAVE_PIN_O <= 1'b0;
         WAVE_PIN_OE_O <= 1'b0;
      end
      else if (CE_I)
      begin
         WAVE_PIN_O <= next_pin;
         WAVE_PIN_OE_O <= pin_dir;
      end
   end

   // read mux; unmapped addresses read as zero
   wire [CNT_W-1:0] cmp_view = is_pwm ? compare_buf : compare_value;
   wire [tmw_pkg::DATA_W-1:0] rd_ctrl = {{(tmw_pkg::DATA_W - tmw_pkg::CTRL_PORT_BIT - 1){1'b0}},
                                          port_level, pin_dir, csel, com, mode};
   wire [tmw_pkg::DATA_W-1:0] rd_status = {{(tmw_pkg::DATA_W - tmw_pkg::STAT_OC_BIT - 1){1'b0}},
                                            waveform_output, compare_match_flag, overflow_flag};
   wire [tmw_pkg::DATA_W-1:0] rd_mux =
      sel_ctrl ? rd_ctrl :
      sel_count ? {{PAD_W{1'b0}}, counter_value} :
      sel_compare ? {{PAD_W{1'b0}}, cmp_view} :
      sel_status ? rd_status : '0;

   // one wait cycle per access; data captured as waitrequest drops
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         AVS_WAITREQUEST_O <= 1'b1;
         AVS_READDATA_O <= '0;
      end
      else if (CE_I)
      begin
         if (req && AVS_WAITREQUEST_O)
         begin
            AVS_WAITREQUEST_O <= 1'b0;
            // writes leave the last read answer standing
            if (AVS_READ_I)
               AVS_READDATA_O <= rd_mux;
         end
         else
            AVS_WAITREQUEST_O <= 1'b1;
      end
   end

endmodule
`default_nettype wire

// [bench/tmw_timer_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the timer block
module tmw_timer_asserts
#(
   parameter int CNT_W = 8
)
(
   input wire logic CORE_CLK_I,
   input wire logic NRST_I,
   input wire logic CE_I,
   input wire logic [tmw_pkg::ADDR_W-1:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [tmw_pkg::DATA_W-1:0] AVS_WRITEDATA_I,
   input wire logic [3:0] AVS_BYTEENABLE_I,
   input wire logic [tmw_pkg::DATA_W-1:0] AVS_READDATA_O,
   input wire logic AVS_WAITREQUEST_O,
   input wire logic WAVE_PIN_O,
   input wire logic WAVE_PIN_OE_O
);
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (!NRST_I);
   // accepted ctrl write with both low lanes
   wire logic ctl_wr = CE_I && AVS_WRITE_I && !AVS_WAITREQUEST_O
      && AVS_ADDRESS_I == tmw_pkg::OFS_CTRL && AVS_BYTEENABLE_I[1:0] == 2'h3;
   // request still waiting for its answer
   wire logic req = CE_I && (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
   wire logic rd_req = CE_I && AVS_READ_I && AVS_WAITREQUEST_O;
   logic [8:0] shadow; // ctrl fields as last written

   // shadow ctrl; partial-lane writes are not tracked, a known limit
   always_ff @(posedge CORE_CLK_I or negedge NRST_I)
   begin
      if (!NRST_I)
      begin
         shadow <= 9'h000;
      end
      else if (ctl_wr)
      begin
         shadow <= AVS_WRITEDATA_I[8:0];
      end
   end

   chk_wait_answer: assert property (req |=> !AVS_WAITREQUEST_O)
      else $error("request not answered one cycle later");
   chk_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("waitrequest low for more than one cycle");
   chk_wait_idle: assert property (CE_I && !AVS_READ_I && !AVS_WRITE_I && AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
      else $error("answer without request");
   chk_rdata_hold: assert property (!rd_req |=> $stable(AVS_READDATA_O))
      else $error("read data moved without read");
   chk_unmapped_zero: assert property (rd_req && AVS_ADDRESS_I[1:0] != 2'h0 |=> AVS_READDATA_O == 32'h0)
      else $error("unmapped read not zero");
   chk_status_high: assert property (rd_req && AVS_ADDRESS_I == tmw_pkg::OFS_STATUS |=> AVS_READDATA_O[31:3] == 29'h0)
      else $error("status upper bits not zero");
   chk_ctrl_readback: assert property (rd_req && AVS_ADDRESS_I == tmw_pkg::OFS_CTRL |=> AVS_READDATA_O[8:0] == $past(shadow))
      else $error("ctrl readback differs");
   chk_oe_follows: assert property (ctl_wr |=> ##[0:1] WAVE_PIN_OE_O == shadow[7])
      else $error("pin enable not following direction");
   chk_pin_port: assert property (ctl_wr && AVS_WRITEDATA_I[3:2] == tmw_pkg::COM_OFF |=> ##[0:1] WAVE_PIN_O == shadow[8])
      else $error("pin not showing port level");
endmodule
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic CORE_CLK_I = 1'b0; // 40 MHz core clock
   logic NRST_I = 1'b0; // async reset, active low
   logic [3:0] addr = 4'h0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] rdata;
   logic waitreq;
   logic pin;
   logic pin_oe;
   logic [31:0] exp_q[$]; // expected read values, masked
   logic [31:0] msk_q[$]; // bits that matter per read
   int n_fail = 0;
   int checks_done = 0;
   int seed = 32'hB7D9;
   int hi;
   int lo;
   int c;
   int w;
   int divs[7] = '{1, 8, 32, 64, 128, 256, 1024};

   // clock enable and lanes tied: every access is a full word
   tmw_timer #(.CNT_W(8)) dut (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .CE_I(1'b1),
      .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
      .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq),
      .WAVE_PIN_O(pin), .WAVE_PIN_OE_O(pin_oe));

   always #12.5 CORE_CLK_I = ~CORE_CLK_I;

   task check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want)
      begin
         n_fail++;
         $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task close_out;
      if (n_fail == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // one bus access, held until waitrequest is sampled low
   task bus(input logic w_n, input logic [3:0] a, input logic [31:0] d);
      rd <= !w_n;
      wr <= w_n;
      addr <= a;
      wdata <= d;
      do @(posedge CORE_CLK_I); while (waitreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge CORE_CLK_I);
   endtask

   // note the expectation, then read
   task rd_chk(input logic [3:0] a, input logic [31:0] want, input logic [31:0] m);
      exp_q.push_back(want);
      msk_q.push_back(m);
      bus(1'b0, a, 32'h0);
   endtask

   // read answers compared against the oldest note
   always @(posedge CORE_CLK_I)
   begin
      if (rd && waitreq === 1'b0 && exp_q.size() > 0)
      begin
         check(rdata & msk_q.pop_front(), exp_q.pop_front());
      end
   end

   function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] com, input logic [2:0] cs,
      input logic dir, input logic lvl);
      return {23'h0, lvl, dir, cs, com, m};
   endfunction

   // cycles until the pin shows v, bounded so a stuck pin cannot hang
   task wait_lvl(input logic v, output int t);
      t = 0;
      while (pin !== v && t < 20000)
      begin
         @(posedge CORE_CLK_I);
         t++;
      end
   endtask

   // settle past buffer load, skip one period, then time high and low
   task measure;
      repeat (520) @(posedge CORE_CLK_I);
      wait_lvl(1'b0, w);
      wait_lvl(1'b1, w);
      wait_lvl(1'b0, w);
      wait_lvl(1'b1, w);
      wait_lvl(1'b0, hi);
      wait_lvl(1'b1, lo);
   endtask

   // pin must sit at v for a whole pwm cycle
   task steady(input logic v);
      int bad;
      bad = 0;
      repeat (600) @(posedge CORE_CLK_I);
      repeat (600)
      begin
         @(posedge CORE_CLK_I);
         if (pin !== v)
            bad++;
      end
      check(32'(bad), 32'h0);
   endtask

   initial
   begin
      repeat (6) @(posedge CORE_CLK_I);
      NRST_I <= 1'b1;
      @(posedge CORE_CLK_I);
      check({30'h0, pin, pin_oe}, 32'h0);
      rd_chk(tmw_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
      rd_chk(tmw_pkg::OFS_STATUS, 32'h0, 32'hFFFFFFFF);
      c = $random(seed);
      rd_chk({c[3:2], 2'h1}, 32'h0, 32'hFFFFFFFF);
      // compare action off: pin shows port level, enable shows direction
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_FAST, tmw_pkg::COM_OFF, tmw_pkg::CSEL_DIV1, 1'b1, 1'b1));
      steady(1'b1);
      check({31'h0, pin_oe}, 32'h1);
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_FAST, tmw_pkg::COM_OFF, tmw_pkg::CSEL_DIV1, 1'b0, 1'b0));
      steady(1'b0);
      check({31'h0, pin_oe}, 32'h0);
      // clear-on-match toggle at every prescale setting
      for (int i = 0; i < 7; i++)
      begin
         c = 1 + ($unsigned($random(seed)) % 2);
         bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLEAR_ON_MATCH, tmw_pkg::COM_TOGGLE, 3'h0, 1'b1, 1'b0));
         bus(1'b1, tmw_pkg::OFS_COUNT, 32'h0);
         // fast runs and a stray tick may have left overflow set
         bus(1'b1, tmw_pkg::OFS_STATUS, 32'h3);
         bus(1'b1, tmw_pkg::OFS_COMPARE, 32'(c));
         bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLEAR_ON_MATCH, tmw_pkg::COM_TOGGLE, 3'(i + 1), 1'b1, 1'b0));
         measure;
         check(32'(hi), 32'((c + 1) * divs[i]));
         check(32'(lo), 32'((c + 1) * divs[i]));
      end
      rd_chk(tmw_pkg::OFS_STATUS, 32'h2, 32'h3);
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLEAR_ON_MATCH, tmw_pkg::COM_TOGGLE, 3'h0, 1'b1, 1'b0));
      bus(1'b1, tmw_pkg::OFS_STATUS, 32'h3);
      rd_chk(tmw_pkg::OFS_STATUS, 32'h0, 32'h3);
      // compare written below the count: match missed until wrap
      bus(1'b1, tmw_pkg::OFS_COUNT, 32'h80);
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'h10);
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_CLEAR_ON_MATCH, tmw_pkg::COM_TOGGLE, 3'h1, 1'b1, 1'b0));
      wait_lvl(~pin, w);
      check(32'(w >= 140 && w <= 150), 32'h1);
      rd_chk(tmw_pkg::OFS_STATUS, 32'h1, 32'h1);
      // normal mode: one toggle per wrap of the full count
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_NORMAL, tmw_pkg::COM_TOGGLE, 3'h1, 1'b1, 1'b0));
      measure;
      check(32'(hi), 32'h100);
      check(32'(lo), 32'h100);
      // fast pwm, both polarities
      c = 16 + ($unsigned($random(seed)) % 200);
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'(c));
      for (int j = 2; j < 4; j++)
      begin
         bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_FAST, 2'(j), 3'h1, 1'b1, 1'b0));
         bus(1'b1, tmw_pkg::OFS_STATUS, 32'h3);
         measure;
         w = (j == 2) ? hi : lo;
         check(32'(hi + lo), 32'h100);
         check(32'(w >= c && w <= c + 1), 32'h1);
         rd_chk(tmw_pkg::OFS_STATUS, 32'h1, 32'h1);
      end
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_FAST, tmw_pkg::COM_TOGGLE, 3'h1, 1'b1, 1'b0));
      measure;
      check(32'(hi + lo), 32'h200);
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_FAST, tmw_pkg::COM_NONINV, 3'h1, 1'b1, 1'b0));
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'h0);
      measure;
      check(32'(hi + lo == 256 && hi >= 1 && hi <= 2), 32'h1);
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'hFF);
      steady(1'b1);
      // phase correct pwm, both polarities
      c = 16 + ($unsigned($random(seed)) % 200);
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'(c));
      rd_chk(tmw_pkg::OFS_COMPARE, 32'(c), 32'hFF);
      for (int j = 2; j < 4; j++)
      begin
         bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_PHASE, 2'(j), 3'h1, 1'b1, 1'b0));
         bus(1'b1, tmw_pkg::OFS_STATUS, 32'h3);
         measure;
         w = (j == 2) ? hi : lo;
         check(32'(hi + lo), 32'h1FE);
         check(32'(w >= 2 * c - 2 && w <= 2 * c + 1), 32'h1);
         rd_chk(tmw_pkg::OFS_STATUS, 32'h1, 32'h1);
      end
      bus(1'b1, tmw_pkg::OFS_CTRL, ctl(tmw_pkg::MODE_PHASE, tmw_pkg::COM_NONINV, 3'h1, 1'b1, 1'b0));
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'h0);
      steady(1'b0);
      bus(1'b1, tmw_pkg::OFS_COMPARE, 32'hFF);
      steady(1'b1);
      close_out;
   end

   // watchdog sized above the expected run of about 40k cycles
   initial
   begin
      repeat (90000) @(posedge CORE_CLK_I);
      n_fail++;
      close_out;
   end
endmodule

bind tmw_timer tmw_timer_asserts #(.CNT_W(CNT_W)) chk (.CORE_CLK_I(CORE_CLK_I), .NRST_I(NRST_I), .CE_I(CE_I),
   .AVS_ADDRESS_I(AVS_ADDRESS_I), .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I),
   .AVS_WRITEDATA_I(AVS_WRITEDATA_I), .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
   .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .WAVE_PIN_O(WAVE_PIN_O), .WAVE_PIN_OE_O(WAVE_PIN_OE_O));
`default_nettype wire
